//--- hdl/fbtp_port.sv
// Tristate memory-bus slave port for a parallel flash with setup, wait and hold timing.
`timescale 1ns/1ps
`default_nettype none
`include "fbtp_regs.svh"
// How it works
// - Serve reads and writes as plain tristate slave, adding only setup, wait, hold.
// - Chip select asserts first; strobe follows after the setup interval.
// - Read or write strobe stays asserted for the wait interval.
// - After write strobe release, chip select holds for the hold interval.
// - Setup, wait, hold share one unit: ns, us, ms or clock cycles.
// - Address and data widths are parameters; master byte enables drive the byte lane enable pins.
// - Address and data pins are shared; chip select and strobes are private.
module fbtp_port #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16,
    parameter int VAL_W = 16
) (
    input wire logic sys_clk_i,                 // System clock, 40 MHz
    input wire logic srst_i,                    // Synchronous reset, active high
    input wire logic [1:0] unit_i,              // Unit shared by all three intervals
    input wire logic [VAL_W-1:0] setup_i,       // Setup interval
    input wire logic [VAL_W-1:0] wait_i,        // Strobe interval
    input wire logic [VAL_W-1:0] hold_i,        // Hold interval
    input wire logic req_i,                     // Master transfer request
    input wire logic wr_i,                      // 1 write, 0 read
    input wire logic [ADDR_W-1:0] addr_i,       // Master word address
    input wire logic [DATA_W-1:0] wdata_i,      // Master write data
    input wire logic [DATA_W/8-1:0] be_i,       // Master byte enables
    output logic busy_o,                        // High while a transfer runs
    output logic done_o,                        // One-cycle completion pulse
    output logic [DATA_W-1:0] rdata_o,          // Read data, registered
    output logic [ADDR_W-1:0] fl_addr_o,        // Shared address pins
    output logic [DATA_W-1:0] fl_data_o,        // Shared data pins, driven value
    output logic fl_data_oe_o,                  // Data pin drive enable
    input wire logic [DATA_W-1:0] fl_data_i,    // Shared data pins, sensed value
    output logic fl_cs_n_o,                     // Private chip select, active low
    output logic fl_rd_n_o,                     // Private read strobe, active low
    output logic fl_wr_n_o,                     // Private write strobe, active low
    output logic [DATA_W/8-1:0] fl_be_n_o       // Byte lane enables, active low
);
    localparam int BE_W = DATA_W / 8;
    fbtp_pkg::fbtp_state_e state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt;
    logic [31:0] setup_cyc_w, wait_cyc_w, hold_cyc_w;
    logic [31:0] wait_cyc_ff, hold_cyc_ff;
    logic wr_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;
    logic [BE_W-1:0] be_ff;
    logic [DATA_W-1:0] sync1_ff, sync2_ff;
    logic cnt_end_w;
    logic idle_w;
    logic sel_w;
    logic rd_stb_w;
    logic wr_stb_w;
    logic rd_last_w;
    logic cap_w;

    // ****************************************
    // Phase decode
    // ****************************************
    // The chip is selected in the setup, strobe and hold phases, not in done; the select pin and the
    // data drive enable share this one decode so the data pins are never driven while unselected.
    function automatic logic fbtp_sel_phase(input fbtp_pkg::fbtp_state_e st);
        fbtp_sel_phase = (st == fbtp_pkg::FBTP_SETUP) || (st == fbtp_pkg::FBTP_STROBE) ||
                         (st == fbtp_pkg::FBTP_HOLD);
    endfunction

    assign idle_w = (state_ff == fbtp_pkg::FBTP_IDLE);
    assign sel_w = fbtp_sel_phase(state_ff);
    assign rd_stb_w = (state_ff == fbtp_pkg::FBTP_STROBE) && !wr_ff;
    assign wr_stb_w = (state_ff == fbtp_pkg::FBTP_STROBE) && wr_ff;
    assign cnt_end_w = (cnt_ff == `FBTP_CNT_ONE);
    assign rd_last_w = rd_stb_w && cnt_end_w;
    assign cap_w = idle_w && req_i;

    // ****************************************
    // Interval conversion
    // ****************************************
    fbtp_cycle_conv #(.VAL_W(VAL_W)) u_conv_setup (
        .unit_i(unit_i),
        .value_i(setup_i),
        .cycles_o(setup_cyc_w)
    );
    fbtp_cycle_conv #(.VAL_W(VAL_W)) u_conv_wait (
        .unit_i(unit_i),
        .value_i(wait_i),
        .cycles_o(wait_cyc_w)
    );
    fbtp_cycle_conv #(.VAL_W(VAL_W)) u_conv_hold (
        .unit_i(unit_i),
        .value_i(hold_i),
        .cycles_o(hold_cyc_w)
    );

    // ****************************************
    // Transfer sequencer
    // ****************************************
    // The counter holds the cycles left in the current phase. A phase ends at
    // the edge where it reads one, so a loaded count of N gives exactly N cycles.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            fbtp_pkg::FBTP_IDLE: begin
                if (req_i) begin
                    nxt_state = fbtp_pkg::FBTP_SETUP;
                    nxt_cnt = setup_cyc_w;
                end
            end
            fbtp_pkg::FBTP_SETUP: begin
                nxt_cnt = cnt_ff - `FBTP_CNT_ONE;
                if (cnt_end_w) begin
                    nxt_state = fbtp_pkg::FBTP_STROBE;
                    nxt_cnt = wait_cyc_ff;
                end
            end
            fbtp_pkg::FBTP_STROBE: begin
                nxt_cnt = cnt_ff - `FBTP_CNT_ONE;
                if (cnt_end_w) begin
                    // Reads need no hold: chip select drops with the strobe.
                    nxt_state = wr_ff ? fbtp_pkg::FBTP_HOLD : fbtp_pkg::FBTP_DONE;
                    nxt_cnt = hold_cyc_ff;
                end
            end
            fbtp_pkg::FBTP_HOLD: begin
                nxt_cnt = cnt_ff - `FBTP_CNT_ONE;
                if (cnt_end_w) begin
                    nxt_state = fbtp_pkg::FBTP_DONE;
                end
            end
            fbtp_pkg::FBTP_DONE: begin
                nxt_state = fbtp_pkg::FBTP_IDLE;
            end
            default: begin
                // Unused state codes fall back to idle rather than lock the port up.
                nxt_state = fbtp_pkg::FBTP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_ff <= fbtp_pkg::FBTP_IDLE;
            cnt_ff <= `FBTP_CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ****************************************
    // Request capture and read sampling
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wr_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= '0;
            be_ff <= '0;
        end else if (cap_w) begin
            wr_ff <= wr_i;
            addr_ff <= addr_i;
            wdata_ff <= wdata_i;
            be_ff <= be_i;
        end
    end

    // The wait and hold counts are frozen at acceptance, so a change of unit or
    // interval while a transfer runs can never mix two units within it.
    // The setup count needs no copy: it is loaded at that same edge.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wait_cyc_ff <= `FBTP_CNT_ZERO;
            hold_cyc_ff <= `FBTP_CNT_ZERO;
        end else if (cap_w) begin
            wait_cyc_ff <= wait_cyc_w;
            hold_cyc_ff <= hold_cyc_w;
        end
    end

    // Flash data is asynchronous to this clock, so it is synchronised first.
    // Once valid, the word stays stable to the end of the strobe, so per-bit capture cannot tear it
    // at the sampling edge as long as the wait interval has the margin below.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= fl_data_i;
            sync2_ff <= sync1_ff;
        end
    end

    // The word taken at the last strobe edge is the one the pins showed two
    // edges earlier, because of the synchroniser. The chip must therefore
    // present valid data at least two cycles before the strobe ends, which
    // the integrator covers by adding two cycles to the wait interval.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_ff <= '0;
        end else if (rd_last_w) begin
            rdata_ff <= sync2_ff;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    assign fl_addr_o = addr_ff;
    assign fl_data_o = wdata_ff;
    // Data pins are driven only on writes and only while selected, so the
    // shared bus is free for the other chips whenever this select is high.
    assign fl_data_oe_o = wr_ff && sel_w;
    assign fl_cs_n_o = !sel_w;
    assign fl_rd_n_o = !rd_stb_w;
    assign fl_wr_n_o = !wr_stb_w;
    assign fl_be_n_o = idle_w ? '1 : ~be_ff;
    assign busy_o = !idle_w;
    assign done_o = (state_ff == fbtp_pkg::FBTP_DONE);
    assign rdata_o = rdata_ff;
endmodule // fbtp_port
`default_nettype wire

//--- hdl/fbtp_regs.svh
// Timing constants and unit codes for the flash bus timing port.
`ifndef FBTP_REGS_SVH
`define FBTP_REGS_SVH
`define FBTP_CLK_HZ 40000000
`define FBTP_PS_PER_NS 1000
`define FBTP_PS_PER_US 1000000
`define FBTP_PS_PER_MS 1000000000
`define FBTP_CLK_PS 25000
`define FBTP_UNIT_NS 2'h0
`define FBTP_UNIT_US 2'h1
`define FBTP_UNIT_MS 2'h2
`define FBTP_UNIT_CYC 2'h3
`define FBTP_SETUP_DEF 16'h0001
`define FBTP_WAIT_DEF 16'h0004
`define FBTP_HOLD_DEF 16'h0001
`define FBTP_CNT_ONE 32'h00000001
`define FBTP_CNT_ZERO 32'h00000000
`endif

//--- hdl/fbtp_pkg.sv
// Types shared by the flash bus timing port.
package fbtp_pkg;
    typedef enum logic [2:0] {
        FBTP_IDLE,
        FBTP_SETUP,
        FBTP_STROBE,
        FBTP_HOLD,
        FBTP_DONE
    } fbtp_state_e;
    typedef logic [1:0] fbtp_unit_t;
endpackage

//--- hdl/fbtp_cycle_conv.sv
// Converts a timing value in a chosen unit into a clock cycle count.
`timescale 1ns/1ps
`default_nettype none
`include "fbtp_regs.svh"
module fbtp_cycle_conv #(
    parameter int VAL_W = 16
) (
    input wire logic [1:0] unit_i,        // Selected unit code
    input wire logic [VAL_W-1:0] value_i, // Interval in that unit
    output logic [31:0] cycles_o          // Whole cycles, rounded up, at least one
);
    logic [63:0] ps_w;
    logic [63:0] cyc_w;
    logic [31:0] raw_w;
    // A 64-bit product keeps milliseconds from overflowing before the divide.
    assign ps_w = (unit_i == `FBTP_UNIT_NS) ? 64'(value_i) * 64'(`FBTP_PS_PER_NS) :
                  (unit_i == `FBTP_UNIT_US) ? 64'(value_i) * 64'(`FBTP_PS_PER_US) :
                  64'(value_i) * 64'(`FBTP_PS_PER_MS);
    assign cyc_w = (ps_w + 64'(`FBTP_CLK_PS) - 64'h1) / 64'(`FBTP_CLK_PS);
    assign raw_w = (unit_i == `FBTP_UNIT_CYC) ? 32'(value_i) : cyc_w[31:0];
    assign cycles_o = (raw_w == `FBTP_CNT_ZERO) ? `FBTP_CNT_ONE : raw_w;
endmodule // fbtp_cycle_conv
`default_nettype wire

//--- sim/fbtp_port_sva.sv
// Timing checker for the flash bus timing port.
`timescale 1ns/1ps
`default_nettype none
module fbtp_port_sva #(parameter int VAL_W = 16) (
    input wire logic sys_clk_i, // Clock
    input wire logic srst_i, // Reset
    input wire logic [1:0] unit_i, // Unit
    input wire logic [VAL_W-1:0] setup_i, // Setup
    input wire logic [VAL_W-1:0] wait_i, // Wait
    input wire logic [VAL_W-1:0] hold_i, // Hold
    input wire logic busy_o, // Busy
    input wire logic done_o, // Done
    input wire logic fl_data_oe_o, // Drive
    input wire logic fl_cs_n_o, // Select
    input wire logic fl_rd_n_o, // Read
    input wire logic fl_wr_n_o // Write
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic [2:0] ph_ff;
    logic [VAL_W-1:0] cnt_ff;
    wire [2:0] ph = {fl_cs_n_o, fl_rd_n_o, fl_wr_n_o};
    wire cyc = unit_i == 2'h3;
    wire st_n = fl_rd_n_o & fl_wr_n_o;
    // Length of the pin phase that has just ended, read at the edge where it changes.
    always_ff @(posedge sys_clk_i) begin
        ph_ff <= ph;
        cnt_ff <= (ph != ph_ff) ? VAL_W'(1) : cnt_ff + VAL_W'(1);
    end
    property p_first; $fell(st_n) |-> !$past(fl_cs_n_o); endproperty
    a_first: assert property (p_first) else $error("strobe before select");
    property p_setup; $fell(st_n) && cyc |-> cnt_ff == setup_i; endproperty
    a_setup: assert property (p_setup) else $error("setup length wrong");
    property p_wait; $rose(st_n) && cyc |-> cnt_ff == wait_i; endproperty
    a_wait: assert property (p_wait) else $error("strobe length wrong");
    property p_hold; $rose(fl_cs_n_o) && $past(fl_data_oe_o) && cyc |-> cnt_ff == hold_i; endproperty
    a_hold: assert property (p_hold) else $error("hold length wrong");
    property p_idle; !busy_o |-> ph == 3'h7 && !fl_data_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("pins active while idle");
    property p_oe; fl_data_oe_o |-> !fl_cs_n_o && fl_rd_n_o; endproperty
    a_oe: assert property (p_oe) else $error("data driven unselected");
    property p_done; done_o |-> busy_o ##1 !done_o; endproperty
    a_done: assert property (p_done) else $error("done not a pulse");
    property p_excl; !fl_rd_n_o |-> fl_wr_n_o && !fl_data_oe_o; endproperty
    a_excl: assert property (p_excl) else $error("read with write");
endmodule // fbtp_port_sva
bind fbtp_port fbtp_port_sva #(.VAL_W(VAL_W)) u_sva (.sys_clk_i, .srst_i, .unit_i, .setup_i, .wait_i,
    .hold_i, .busy_o, .done_o, .fl_data_oe_o, .fl_cs_n_o, .fl_rd_n_o, .fl_wr_n_o);
`default_nettype wire

//--- sim/fbtp_flash_model.sv
// Behavioural parallel flash chip on the shared bus.
`timescale 1ns/1ps
`default_nettype none
module fbtp_flash_model (
    input wire logic clk_i, // Clock
    input wire logic [1:0] lat_i, // Access delay, strobe cycles
    input wire logic [7:0] addr_i, // Low address
    input wire logic [15:0] bus_i, // Resolved data pins
    input wire logic [1:0] be_n_i, // Lanes, active low
    input wire logic cs_n_i, // Select, active low
    input wire logic rd_n_i, // Read, active low
    input wire logic wr_n_i, // Write, active low
    output logic [15:0] data_o // Driven data
);
    logic [15:0] mem [256];
    logic [15:0] junk_ff = 16'h5a3c;
    logic [1:0] age_ff = 2'h0;
    // Outside a valid read the pins wander, so stale data never passes for a good read.
    assign data_o = (!cs_n_i && !rd_n_i && age_ff >= lat_i) ? mem[addr_i] : junk_ff;
    always_ff @(posedge clk_i) begin
        junk_ff <= ~{junk_ff[14:0], junk_ff[15]};
        age_ff <= rd_n_i ? 2'h0 : (age_ff == 2'h3 ? age_ff : age_ff + 2'h1);
        for (int b = 0; b < 2; b++) begin
            if (!cs_n_i && !wr_n_i && !be_n_i[b]) begin
                mem[addr_i][8*b +: 8] <= bus_i[8*b +: 8];
            end
        end
    end
endmodule // fbtp_flash_model
`default_nettype wire

//--- sim/test_fbtp_port.sv
// Self-checking bench for the flash bus timing port.
`timescale 1ns/1ps
`default_nettype none
module test_fbtp_port;
    logic sys_clk_i = 1'h0, srst_i = 1'h1, req_i = 1'h0, wr_i = 1'h0;
    logic [1:0] unit_i = 2'h3, lat = 2'h0, be_i = 2'h3;
    logic [15:0] setup_i = 16'h1, wait_i = 16'h2, hold_i = 16'h1, wdata_i = 16'h0, fl_data_i, fl_data_o, rdata_o;
    logic [21:0] addr_i = 22'h0, fl_addr_o;
    logic [1:0] fl_be_n_o;
    logic busy_o, done_o, fl_data_oe_o, fl_cs_n_o, fl_rd_n_o, fl_wr_n_o;
    logic [15:0] ref_mem [8];
    logic [31:0] seed = 32'h00013b33;
    int miscompares = 0, checks_done = 0, n;
    fbtp_port dut (.*);
    fbtp_flash_model u_flash (.clk_i(sys_clk_i), .lat_i(lat), .addr_i(fl_addr_o[7:0]),
        .bus_i(fl_data_oe_o ? fl_data_o : fl_data_i), .be_n_i(fl_be_n_o), .cs_n_i(fl_cs_n_o),
        .rd_n_i(fl_rd_n_o), .wr_n_i(fl_wr_n_o), .data_o(fl_data_i));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    function automatic int cyc(input logic [1:0] u, input logic [15:0] v);
        longint ps = u == 2'h0 ? 1000 : u == 2'h1 ? 1000000 : 1000000000;
        cyc = u == 2'h3 ? int'(v) : int'((v * ps + 24999) / 25000);
        if (cyc == 0) cyc = 1;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task set(input logic [1:0] u, input int s, input int w, input int h, input logic [1:0] l);
        @(posedge sys_clk_i);
        unit_i <= u;
        setup_i <= 16'(s);
        wait_i <= 16'(w);
        hold_i <= 16'(h);
        lat <= l;
    endtask
    task xfer(input logic w, input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
        int e;
        @(posedge sys_clk_i);
        req_i <= 1'h1;
        wr_i <= w;
        addr_i <= 22'(a);
        wdata_i <= d;
        be_i <= be;
        @(posedge sys_clk_i);
        req_i <= 1'h0;
        e = cyc(unit_i, setup_i) + cyc(unit_i, wait_i) + (w ? cyc(unit_i, hold_i) : 0) + 1;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (done_o !== 1'h1 && n < 50000);
        if (done_o !== 1'h1) begin
            miscompares++;
            $display("[FAIL] done timeout expected 1 seen %h", done_o);
            test_done;
        end
        chk("done delay", e, n);
        if (w) for (int b = 0; b < 2; b++) begin
            if (be[b]) ref_mem[a][8*b +: 8] = d[8*b +: 8];
        end
        else chk("read data", ref_mem[a], rdata_o);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'h0;
        @(negedge sys_clk_i);
        chk("idle pins", 4'he, {fl_cs_n_o, fl_rd_n_o, fl_wr_n_o, busy_o});
        for (int i = 0; i < 8; i++) xfer(1'h1, 3'(i), 16'(i * 16'h1111 + 16'h0f0f), 2'h3);
        // The strobe covers the access delay plus the two synchroniser stages of read data.
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            set(2'h3, seed[3:2] + 1, seed[0] + seed[4] + 3, seed[6:5] + 1, {1'h0, seed[0]});
            xfer(seed[7], seed[10:8], seed[26:11], seed[28:27]);
        end
        for (int u = 0; u < 3; u++) begin
            set(2'(u), u == 0 ? 30 : u == 1 ? 1 : 0, u == 0 ? 80 : 0, u == 0 ? 0 : 1, 2'h0);
            xfer(1'h1, 3'(u), 16'hc3a5 ^ 16'(u), 2'h1 << (u % 2));
        end
        set(2'h3, 1, 3, 1, 2'h0);
        for (int u = 0; u < 3; u++) xfer(1'h0, 3'(u), 16'h0, 2'h3);
        // A second reset in mid-run must clear the captured address and read data.
        @(posedge sys_clk_i);
        srst_i <= 1'h1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'h0;
        @(negedge sys_clk_i);
        chk("reset pins", 7'h73, {fl_cs_n_o, fl_rd_n_o, fl_wr_n_o, busy_o, done_o, fl_be_n_o});
        chk("reset rdata", 32'h0, rdata_o);
        chk("reset address", 32'h0, fl_addr_o);
        test_done;
    end
endmodule // test_fbtp_port
`default_nettype wire
